// file: cfg_host_model.sv
// Host model: drives the parallel port pins and the test access port.
// Assumes clk is the loader's system clock and busy is its output.
`timescale 1ns/100ps
module cfg_host_model (
  // Clock and loader status.
  input  wire logic          clk,
  input  wire logic          busy,
  // Pins toward the loader.
  output logic               configClock,
  output cfg_load_pkg::par_pins_t parPins,
  output cfg_load_pkg::tap_pins_t tapPins
);
  import cfg_load_pkg::*;

  // Set when a busy wait ran out of its bound.
  logic stuck = 1'b0;

  // Idle pins: select and write released, clocks still.
  initial begin
    configClock = 1'b0;
    parPins = '{csN: 1'b1, writeN: 1'b1, parallelDataByte: 8'h00};
    tapPins = '0;
  end

  // One byte; a busy loader is waited out with the byte held back.
  task automatic put_byte(input logic cs, input logic wr,
                          input logic [7:0] b);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) stuck = 1'b1;
    @(negedge clk);
    // A released write with select low asks for an abort.
    parPins = '{csN: cs, writeN: wr, parallelDataByte: b};
    #32 configClock = 1'b1;
    #32 configClock = 1'b0;
  endtask : put_byte

  // Select released; the data lines stop showing the last byte.
  task automatic release_cs();
    @(negedge clk);
    parPins.csN = 1'b1;
    parPins.writeN = 1'b1;
    parPins.parallelDataByte = ~parPins.parallelDataByte;
  endtask : release_cs

  // One test clock pulse with mode and data set up before it.
  task automatic tck_bit(input logic ms, input logic di);
    @(negedge clk);
    tapPins.tms = ms;
    tapPins.tdi = di;
    #32 tapPins.tck = 1'b1;
    #32 tapPins.tck = 1'b0;
  endtask : tck_bit

  // Shifts n bits, then goes through Exit1 and Update back to idle.
  task automatic shift(input logic [31:0] v, input int n, input logic lsb);
    for (int i = 0; i < n; i++) begin
      tck_bit(i == n - 1, lsb ? v[i] : v[n - 1 - i]);
    end
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
  endtask : shift

  // Test logic reset, then idle.
  task automatic tap_reset();
    repeat (5) tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
  endtask : tap_reset

  // Instruction load from idle, lowest bit first.
  task automatic ir(input logic [4:0] code);
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
    tck_bit(1'b0, 1'b0);
    shift(32'(code), 5, 1'b1);
  endtask : ir

  // Data shift from idle, top bit first, n test clocks in Shift-DR.
  task automatic dr(input logic [31:0] v, input int n);
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
    tck_bit(1'b0, 1'b0);
    shift(v, n, 1'b0);
  endtask : dr
endmodule : cfg_host_model

// file: cfg_load_pkg.sv
// Shared constants and types for the configuration loader.
// Assumes a single 200 MHz system clock that samples every pin of the
// parallel port and of the test access port.
package cfg_load_pkg;

  // System clock period and abort busy time.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ABORT_TIME_NS = 100;
  localparam int ABORT_CYCLES  =
    (ABORT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ABORT_W       = $clog2(ABORT_CYCLES + 1);

  // Configuration bus word and synchronization word default.
  localparam int          WORD_W            = 32;
  localparam logic [31:0] SYNC_WORD_DEFAULT = 32'h5A5A_C3C3;

  // Test access port instruction register and codes.
  localparam int         IR_LEN         = 5;
  localparam logic [4:0] IR_CONFIG_IN   = 5'h05;
  localparam logic [4:0] IR_STARTUP_SEQ = 5'h0C;
  localparam logic [4:0] IR_BYPASS      = 5'h1F;
  localparam logic [4:0] IR_CAPTURE     = 5'h01;
  localparam int         STARTUP_CYCLES_DEFAULT = 12;

  // Mode pin pattern one, zero, don't-care on pins 0, 1, 2.
  localparam logic [2:0] MODE_SCAN_MASK  = 3'h3;
  localparam logic [2:0] MODE_SCAN_VALUE = 3'h1;

  // Byte-wide slave parallel port pins.
  typedef struct packed {
    logic       csN;
    logic       writeN;
    logic [7:0] parallelDataByte;
  } par_pins_t;

  // Test access port input pins.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

  // Every pin sampled by the system clock.
  typedef struct packed {
    logic       configClock;
    par_pins_t  par;
    tap_pins_t  tap;
    logic [2:0] modeSelectPins;
  } pin_sample_t;

  // Pin values after reset: select and write released, clocks low, so
  // that no stage of the synchronizer starts away from the idle level.
  localparam pin_sample_t PIN_IDLE = '{
    configClock: 1'b0,
    par: '{csN: 1'b1, writeN: 1'b1, parallelDataByte: 8'h00},
    tap: '{tck: 1'b0, tms: 1'b0, tdi: 1'b0},
    modeSelectPins: 3'h0};

  // One word on the internal configuration bus.
  typedef struct packed {
    logic              valid;
    logic              fromScan;
    logic [WORD_W-1:0] data;
  } cfg_word_t;

  // Test access port controller states.
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040,
    EX2_DR = 16'h0080, UPD_DR = 16'h0100, SEL_IR = 16'h0200,
    CAP_IR = 16'h0400, SH_IR = 16'h0800, EX1_IR = 16'h1000,
    PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
  } tap_state_t;

endpackage : cfg_load_pkg

// file: config_load_parallel_jtag.sv
// Configuration loader: byte-wide slave parallel port plus scan port.
// Assumes all pins come from outside the clk domain; the configuration
// clock and the test clock are sampled and their edges found on clk.
`timescale 1ns/100ps

module config_load_parallel_jtag
  import cfg_load_pkg::*;
#(
  parameter logic [31:0] SYNC_WORD      = cfg_load_pkg::SYNC_WORD_DEFAULT,
  parameter int          STARTUP_CYCLES =
    cfg_load_pkg::STARTUP_CYCLES_DEFAULT
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Parallel port and mode pins.
  input  wire logic                    configClock,
  input  wire cfg_load_pkg::par_pins_t parPins,
  input  wire logic [2:0]              modeSelectPins,
  output logic                         busy,
  // Test access port.
  input  wire cfg_load_pkg::tap_pins_t tapPins,
  output logic                         tdo,
  output logic                         tdoOeN,
  // Internal configuration bus and status.
  output cfg_load_pkg::cfg_word_t      cfgWord,
  input  wire logic                    cfgReady,
  output logic                         syncLocked,
  output logic                         scanMode,
  output logic                         startupDone
);
  import cfg_load_pkg::*;

  // Refuse startup counts that the counter cannot hold.
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 255) begin : g_bad_startup
    $error("STARTUP_CYCLES must lie between 1 and 255.");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Three-stage pin synchronizer with agreement filter.
  pin_sample_t rawIn, sync1, sync2, sync3, filt, next_filt;
  assign rawIn = {configClock, parPins, tapPins, modeSelectPins};

  // A bit changes only once the second and third stages agree.
  always_comb begin
    next_filt = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      filt  <= PIN_IDLE;
    end else begin
      sync1 <= rawIn;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  // Edge strobes and sampled pin values.
  logic       linkRise, tckRise, tckFall;
  logic [7:0] byteIn;
  assign linkRise = ~filt.configClock & next_filt.configClock;
  assign tckRise  = ~filt.tap.tck & next_filt.tap.tck;
  assign tckFall  = filt.tap.tck & ~next_filt.tap.tck;
  assign byteIn   = next_filt.par.parallelDataByte;
  assign scanMode = (filt.modeSelectPins & MODE_SCAN_MASK)
                    == MODE_SCAN_VALUE;

  // Parallel port state.
  logic               aligned, next_aligned;
  logic [23:0]        history, next_history;
  logic [1:0]         byteCnt, next_byteCnt;
  logic [ABORT_W-1:0] abortCnt, next_abortCnt;
  logic               abortStart, byteTake, parEmit, tapEmit;
  logic [31:0]        parData, tapData;

  // Busy only for an abort or a word the bus has not yet taken.
  assign busy = (abortCnt != '0) | (cfgWord.valid & ~cfgReady);
  // Select high ignores every clock edge; scan mode locks the port out.
  assign abortStart = linkRise & ~next_filt.par.csN
                      & next_filt.par.writeN & ~scanMode
                      & (abortCnt == '0);
  assign byteTake = linkRise & ~next_filt.par.csN
                    & ~next_filt.par.writeN & ~scanMode & ~busy
                    & ~tapEmit;
  assign syncLocked = aligned;

  // Byte packing, sync search and abort sequencing.
  always_comb begin
    next_aligned  = aligned;
    next_history  = history;
    next_byteCnt  = byteCnt;
    next_abortCnt = abortCnt;
    parEmit       = 1'b0;
    parData       = {history, byteIn};
    if (abortCnt != '0) begin
      next_abortCnt = abortCnt - 1'b1;
    end
    if (abortStart) begin
      next_abortCnt = ABORT_W'(ABORT_CYCLES);
      next_aligned  = 1'b0;
      next_history  = '0;
      next_byteCnt  = '0;
    end else if (byteTake) begin
      next_history = {history[15:0], byteIn};
      if (!aligned) begin
        if ({history, byteIn} == SYNC_WORD) begin
          next_aligned = 1'b1;
          next_byteCnt = '0;
        end
      end else begin
        next_byteCnt = byteCnt + 1'b1;
        parEmit      = (byteCnt == 2'h3);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aligned  <= 1'b0;
      history  <= '0;
      byteCnt  <= '0;
      abortCnt <= '0;
    end else begin
      aligned  <= next_aligned;
      history  <= next_history;
      byteCnt  <= next_byteCnt;
      abortCnt <= next_abortCnt;
    end
  end

  // Test access port controller next state.
  function automatic tap_state_t tap_next(tap_state_t s, logic tms);
    case (s)
      TLR:     tap_next = tms ? TLR : RTI;
      RTI:     tap_next = tms ? SEL_DR : RTI;
      SEL_DR:  tap_next = tms ? SEL_IR : CAP_DR;
      CAP_DR:  tap_next = tms ? EX1_DR : SH_DR;
      SH_DR:   tap_next = tms ? EX1_DR : SH_DR;
      EX1_DR:  tap_next = tms ? UPD_DR : PA_DR;
      PA_DR:   tap_next = tms ? EX2_DR : PA_DR;
      EX2_DR:  tap_next = tms ? UPD_DR : SH_DR;
      UPD_DR:  tap_next = tms ? SEL_DR : RTI;
      SEL_IR:  tap_next = tms ? TLR : CAP_IR;
      CAP_IR:  tap_next = tms ? EX1_IR : SH_IR;
      SH_IR:   tap_next = tms ? EX1_IR : SH_IR;
      EX1_IR:  tap_next = tms ? UPD_IR : PA_IR;
      PA_IR:   tap_next = tms ? EX2_IR : PA_IR;
      EX2_IR:  tap_next = tms ? UPD_IR : SH_IR;
      UPD_IR:  tap_next = tms ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction : tap_next

  // Scan port state.
  tap_state_t        tapState, next_tapState;
  logic [IR_LEN-1:0] irShift, next_irShift, irCur, next_irCur;
  logic [31:0]       drShift, next_drShift;
  logic [4:0]        bitCnt, next_bitCnt;
  logic [7:0]        startCnt, next_startCnt;
  logic              bypassBit, next_bypassBit;
  logic              next_startupDone, next_tdo, next_tdoOeN;

  // Instruction decode, bitstream shifting and startup counting.
  always_comb begin
    next_tapState    = tapState;
    next_irShift     = irShift;
    next_irCur       = irCur;
    next_drShift     = drShift;
    next_bitCnt      = bitCnt;
    next_startCnt    = startCnt;
    next_bypassBit   = bypassBit;
    next_startupDone = startupDone;
    next_tdo         = tdo;
    next_tdoOeN      = tdoOeN;
    tapEmit          = 1'b0;
    tapData          = {drShift[30:0], next_filt.tap.tdi};
    if (tckRise) begin
      next_tapState = tap_next(tapState, next_filt.tap.tms);
      case (tapState)
        TLR:    next_irCur = IR_BYPASS;
        CAP_IR: next_irShift = IR_CAPTURE;
        SH_IR:  next_irShift = {next_filt.tap.tdi, irShift[IR_LEN-1:1]};
        UPD_IR: begin
          next_irCur    = irShift;
          next_bitCnt   = '0;
          next_startCnt = '0;
        end
        CAP_DR: next_bypassBit = 1'b0;
        SH_DR: begin
          if (irCur == IR_CONFIG_IN) begin
            next_drShift = tapData;
            next_bitCnt  = bitCnt + 1'b1;
            tapEmit      = (bitCnt == 5'h1F);
          end else if (irCur == IR_STARTUP_SEQ) begin
            next_startCnt = startCnt + 1'b1;
            if (startCnt == 8'(STARTUP_CYCLES - 1)) begin
              next_startupDone = 1'b1;
            end
          end else begin
            next_bypassBit = next_filt.tap.tdi;
          end
        end
        default: next_irCur = irCur;
      endcase
    end
    // The data output changes on the falling test clock edge.
    if (tckFall) begin
      next_tdoOeN = ~(tapState == SH_IR || tapState == SH_DR);
      if (tapState == SH_IR) begin
        next_tdo = irShift[0];
      end else if (irCur == IR_CONFIG_IN) begin
        next_tdo = drShift[31];
      end else begin
        next_tdo = bypassBit;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tapState    <= TLR;
      irShift     <= '0;
      irCur       <= IR_BYPASS;
      drShift     <= '0;
      bitCnt      <= '0;
      startCnt    <= '0;
      bypassBit   <= 1'b0;
      startupDone <= 1'b0;
      tdo         <= 1'b0;
      tdoOeN      <= 1'b1;
    end else begin
      tapState    <= next_tapState;
      irShift     <= next_irShift;
      irCur       <= next_irCur;
      drShift     <= next_drShift;
      bitCnt      <= next_bitCnt;
      startCnt    <= next_startCnt;
      bypassBit   <= next_bypassBit;
      startupDone <= next_startupDone;
      tdo         <= next_tdo;
      tdoOeN      <= next_tdoOeN;
    end
  end

  // Configuration bus word holding register; scan words take priority.
  cfg_word_t next_cfgWord;
  always_comb begin
    next_cfgWord = cfgWord;
    if (cfgWord.valid && cfgReady) begin
      next_cfgWord.valid = 1'b0;
    end
    if (tapEmit) begin
      next_cfgWord = '{valid: 1'b1, fromScan: 1'b1, data: tapData};
    end else if (parEmit) begin
      next_cfgWord = '{valid: 1'b1, fromScan: 1'b0, data: parData};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgWord <= '0;
    end else begin
      cfgWord <= next_cfgWord;
    end
  end

  // Checks on the documented behaviour.
  a_select_high_ignored: assert property (
    linkRise && next_filt.par.csN
    |=> history == $past(history) && aligned == $past(aligned))
    else $error("Edge taken while chip select was high.");
  a_abort_busy_hold: assert property (
    abortStart |=> busy [*8] ##0 (abortCnt == ABORT_W'(ABORT_CYCLES - 7)))
    else $error("Busy did not cover the abort.");
  a_abort_loses_sync: assert property (
    abortStart |=> !aligned && byteCnt == 2'h0)
    else $error("Alignment survived an abort.");
  a_word_needs_sync: assert property (
    $rose(cfgWord.valid) && !cfgWord.fromScan |-> $past(aligned))
    else $error("Parallel word emitted without sync.");
  a_busy_cause: assert property (
    busy |-> abortCnt != '0 || (cfgWord.valid && !cfgReady))
    else $error("Busy raised without cause.");
  a_scan_lockout: assert property (
    scanMode |-> !byteTake && !abortStart)
    else $error("Parallel port active in scan mode.");
  a_scan_word_out: assert property (
    tapEmit |=> cfgWord.valid && cfgWord.fromScan
                && cfgWord.data == $past(tapData))
    else $error("Scan word not placed on the bus.");
  a_scan_any_mode: assert property (
    tckRise && tapState == SH_DR && irCur == IR_CONFIG_IN
    |=> bitCnt == $past(bitCnt) + 5'h01)
    else $error("Scan shift did not advance.");
  a_startup_count: assert property (
    $rose(startupDone) |-> $past(irCur) == IR_STARTUP_SEQ
                           && $past(startCnt) == 8'(STARTUP_CYCLES - 1))
    else $error("Startup finished at the wrong count.");

endmodule : config_load_parallel_jtag

// file: config_load_parallel_jtag_tb.sv
// Self-checking bench for the configuration loader and its host model.
// Assumes the package, the loader and the host model are compiled first.
`timescale 1ns/100ps
module config_load_parallel_jtag_tb;
  import cfg_load_pkg::*;
  localparam int STARTUP_N = 6;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        configClock;
  par_pins_t   parPins;
  tap_pins_t   tapPins;
  logic [2:0]  modeSelectPins = 3'h0;
  logic        cfgReady = 1'b1;
  logic        busy, tdo, tdoOeN, syncLocked, scanMode, startupDone;
  cfg_word_t   cfgWord;
  logic [32:0] expQ[$];
  logic [31:0] seed = 32'h1458_f64a;
  logic [31:0] w;
  logic        busySeen = 1'b0;
  int          busyRun = 0;
  int          lastRun = 0;
  int          error_cnt = 0;
  int          tests_run = 0;

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  config_load_parallel_jtag #(.STARTUP_CYCLES(STARTUP_N)) i_dut (
    .clk(clk), .rst(rst), .configClock(configClock), .parPins(parPins),
    .modeSelectPins(modeSelectPins), .busy(busy), .tapPins(tapPins),
    .tdo(tdo), .tdoOeN(tdoOeN), .cfgWord(cfgWord), .cfgReady(cfgReady),
    .syncLocked(syncLocked), .scanMode(scanMode),
    .startupDone(startupDone));

  cfg_host_model i_host (
    .clk(clk), .busy(busy), .configClock(configClock),
    .parPins(parPins), .tapPins(tapPins));

  // Xorshift source of data words.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check_val(input string what, input logic [32:0] exp,
                           input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_flag(input string what, input logic exp,
                            input logic got);
    check_val(what, {32'h0000_0000, exp}, {32'h0000_0000, got});
  endtask : check_flag

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Words are compared against the oldest note; busy runs are measured.
  always @(posedge clk) begin
    if (cfgWord.valid === 1'b1 && cfgReady === 1'b1) begin
      if (expQ.size() == 0) begin
        error_cnt++;
        $display("BAD word expected none seen %h", cfgWord.data);
      end else check_val("word", expQ.pop_front(),
                         {cfgWord.fromScan, cfgWord.data});
    end
    if (busy === 1'b1) begin
      busySeen <= 1'b1;
      busyRun <= busyRun + 1;
    end else if (busyRun != 0) begin
      lastRun <= busyRun;
      busyRun <= 0;
    end
  end

  // Waits until every noted word came out and busy fell, then idles.
  task automatic wait_q();
    int n;
    n = 0;
    while ((expQ.size() != 0 || busy === 1'b1) && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000 || i_host.stuck === 1'b1) begin
      error_cnt++;
      $display("BAD wait expected done seen timeout");
      tally_and_finish();
    end
    repeat (40) @(negedge clk);
  endtask : wait_q

  // Four bytes, top byte first, select optionally dropped in between.
  task automatic send(input logic [31:0] v, input logic cs,
                      input logic split);
    for (int i = 3; i >= 0; i--) begin
      i_host.put_byte(cs, 1'b0, v[8*i+:8]);
      if (split) i_host.release_cs();
    end
    i_host.release_cs();
  endtask : send

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (8) @(negedge clk);
    // Sync, then a word in separate select sequences, with edges of a
    // deselected port in between that must leave alignment alone.
    check_flag("syncLocked", 1'b0, syncLocked);
    send(SYNC_WORD_DEFAULT, 1'b0, 1'b1);
    check_flag("syncLocked", 1'b1, syncLocked);
    send(rnd(), 1'b1, 1'b0);
    w = rnd();
    expQ.push_back({1'b0, w});
    send(w, 1'b0, 1'b1);
    wait_q();
    check_flag("busy seen", 1'b0, busySeen);
    // A stalled bus raises busy and holds the word until taken.
    cfgReady = 1'b0;
    w = rnd();
    expQ.push_back({1'b0, w});
    send(w, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    check_flag("stall busy", 1'b1, busy);
    cfgReady = 1'b1;
    wait_q();
    $display("test parallel done");
    // Abort in mid-word: busy for the abort time, then sync is needed.
    i_host.put_byte(1'b0, 1'b0, 8'h3C);
    i_host.put_byte(1'b0, 1'b1, 8'hA5);
    check_flag("abort busy", 1'b1, busy);
    i_host.release_cs();
    wait_q();
    check_val("busy run", 33'(ABORT_CYCLES), 33'(lastRun));
    check_flag("syncLocked", 1'b0, syncLocked);
    send(rnd(), 1'b0, 1'b0);
    send(SYNC_WORD_DEFAULT, 1'b0, 1'b0);
    w = rnd();
    expQ.push_back({1'b0, w});
    send(w, 1'b0, 1'b0);
    wait_q();
    $display("test abort done");
    // Scan configuration with a non-scan mode, then startup count.
    modeSelectPins = 3'h6;
    i_host.tap_reset();
    i_host.ir(IR_CONFIG_IN);
    w = rnd();
    expQ.push_back({1'b1, w});
    i_host.dr(w, 32);
    wait_q();
    check_flag("tdoOeN idle", 1'b1, tdoOeN);
    check_flag("tdo", w[31], tdo);
    i_host.ir(IR_STARTUP_SEQ);
    i_host.dr(32'h0000_0000, STARTUP_N - 1);
    check_flag("startupDone", 1'b0, startupDone);
    i_host.dr(32'h0000_0000, 1);
    check_flag("startupDone", 1'b1, startupDone);
    $display("test scan done");
    // Every mode pattern; scan mode kills the parallel port only.
    for (int m = 0; m < 8; m++) begin
      modeSelectPins = 3'(m);
      repeat (10) @(negedge clk);
      check_flag("scanMode", m[0] & ~m[1], scanMode);
    end
    modeSelectPins = 3'h5;
    repeat (10) @(negedge clk);
    send(SYNC_WORD_DEFAULT, 1'b0, 1'b0);
    send(rnd(), 1'b0, 1'b0);
    i_host.ir(IR_CONFIG_IN);
    w = rnd();
    expQ.push_back({1'b1, w});
    i_host.dr(w, 32);
    wait_q();
    $display("test mode done");
    tally_and_finish();
  end
endmodule : config_load_parallel_jtag_tb
